//--- aqc_corr.sv
`timescale 1ns/1ps
module aqc_corr (
	input wire logic [7:0] hdr_i,
	input wire aqc_pkg::aqc_cd_e state_i,
	output logic valid_o,
	output logic [3:0] sn_o,
	output logic crc_err_o,
	output logic par_err_o,
	output logic hdr_err_o,
	output aqc_pkg::aqc_cd_e nxt_state_o
);
	// ==========================================================
	// CRC over the four protected bits
	function automatic logic [2:0] crc3(input logic [3:0] d);
		logic [2:0] r;
		logic fb;
		r = 3'h0;
		for (int i = 3; i >= 0; i--)
		begin
			fb = d[i] ^ r[2];
			r = {r[1:0], 1'b0} ^ (fb ? aqc_pkg::CRC_POLY : 3'h0);
		end
		return r;
	endfunction : crc3

	wire [3:0] data = hdr_i[aqc_pkg::HDR_CSI_BIT:aqc_pkg::HDR_SN_LSB];
	wire [2:0] syndrome = crc3(data) ^ hdr_i[aqc_pkg::HDR_CRC_MSB:aqc_pkg::HDR_CRC_LSB];
	logic [3:0] fixed;

	assign crc_err_o = |syndrome;
	assign par_err_o = ^hdr_i;
	assign hdr_err_o = crc_err_o | par_err_o;

	// A syndrome that points at a CRC bit leaves the data bits as received.
	always_comb
	begin
		fixed = data;
		for (int i = 0; i < 4; i++)
		begin
			if (crc3(4'h1 << i) == syndrome)
				fixed[i] = ~data[i];
		end
	end

	always_comb
	begin
		sn_o = data;
		valid_o = ~hdr_err_o;
		nxt_state_o = hdr_err_o ? aqc_pkg::CD_DETECT : aqc_pkg::CD_CORRECT;
		if (state_i == aqc_pkg::CD_CORRECT && par_err_o)
		begin
			valid_o = 1'b1;
			if (crc_err_o)
				sn_o = fixed;
		end
		// CRC error alone stays invalid in either state.
		if (crc_err_o && !par_err_o)
			valid_o = 1'b0;
	end
endmodule : aqc_corr

//--- aqc_fifo.sv
`timescale 1ns/1ps
module aqc_fifo #(
	parameter int WIDTH = aqc_pkg::FIFO_WIDTH,
	parameter int DEPTH = aqc_pkg::FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW:0] wr_ptr_ff;
	logic [AW:0] rd_ptr_ff;

	wire empty = wr_ptr_ff == rd_ptr_ff;
	wire full = (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]) && (wr_ptr_ff[AW] != rd_ptr_ff[AW]);
	wire do_wr = in_valid_i && !full;
	wire do_rd = out_ready_i && !empty;

	assign in_ready_o = !full;
	assign out_valid_o = !empty;
	assign out_data_o = mem_ff[rd_ptr_ff[AW-1:0]];

	always_ff @(posedge clk_i)
	begin
		if (do_wr)
			mem_ff[wr_ptr_ff[AW-1:0]] <= in_data_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
		end
		else
		begin
			wr_ptr_ff <= wr_ptr_ff + (AW+1)'(do_wr);
			rd_ptr_ff <= rd_ptr_ff + (AW+1)'(do_rd);
		end
	end
endmodule : aqc_fifo

//--- aqc_pkg.sv
// Summary of operation
// - A parity error, with or without a CRC error, is a correctable single-bit error.
// - A CRC error without a parity error is uncorrectable and reported invalid.
// - Correction state: clean byte valid, +0, stay; parity-only valid, +1, to detection.
// - Correction state: CRC and parity corrected and valid; CRC-only invalid; both +1, detection.
// - Detection state: any error invalid, +1, stay; clean byte valid, +0, to correction.
// - An uncorrectable byte still outputs the received sequence number with validity low.
// - The correction stage gives a validity flag and intended sequence number per cell.
// - Top bit of the four-bit value is CSI; lower three bits are the sequence number.
// - After each cell the next correction state and header error count are written back.
// - Every header byte, even uncorrectable, goes with its validity to the ordering stage.
// - Unlocked: valid out-of-order cell dropped, stay; invalid cell dropped, back to start.
// - Unlocked: in-order cell accepted, enter sync and arm the late-cell timer.
// - Sync, apparent single loss: write one dummy, then the cell, enter loss state.
// - Loss state: next cell confirming the loss is stored and sync is resumed.
// - Loss state: a misinsertion returns to sync and drops the late arriving cell.
// - Loss state: a protection failure returns to sync and drops the latest cell.
// - Late check enabled and timer at its limit: write one dummy, enter late state.
// - Late state: the originally expected cell was only late; drop it, back to sync.
// - Late state: a cell one beyond the expected is a single loss; store it, sync.
package aqc_pkg;
	// ==========================================================
	// Header byte layout
	localparam int HDR_CSI_BIT = 7;
	localparam int HDR_SN_MSB = 6;
	localparam int HDR_SN_LSB = 4;
	localparam int HDR_CRC_MSB = 3;
	localparam int HDR_CRC_LSB = 1;
	localparam int SN_W = 3;
	localparam logic [2:0] CRC_POLY = 3'h3;
	localparam logic [2:0] SN_STEP = 3'h1;
	localparam logic [2:0] SN_STEP2 = 3'h2;
	// ==========================================================
	// Counters, buffer and reset values
	localparam int ERR_CNT_W = 8;
	localparam logic [7:0] ERR_CNT_RST = 8'h00;
	localparam logic [7:0] ERR_CNT_INC = 8'h01;
	localparam int LATE_CNT_W = 16;
	localparam int FIFO_DEPTH = 4;
	localparam int FIFO_WIDTH = 4;
	// ==========================================================
	// State encodings
	typedef enum logic {CD_CORRECT, CD_DETECT} aqc_cd_e;
	typedef enum logic [2:0] {
		FS_RESET, FS_START, FS_UNLOCKED, FS_SYNC,
		FS_INVALID, FS_OUT_OF_SEQ, FS_LOSS_MIS, FS_LATE_INS
	} aqc_fast_e;
endpackage : aqc_pkg

//--- aqc_seq_checker.sv
`timescale 1ns/1ps
module aqc_seq_checker #(
	parameter int LATE_W = aqc_pkg::LATE_CNT_W,
	parameter int DEPTH = aqc_pkg::FIFO_DEPTH
) (
	input wire logic CLK_SYS_I,
	input wire logic RESET_N_I,
	input wire logic CELL_VALID_I,
	output logic CELL_READY_O,
	input wire logic [7:0] CELL_HDR_I,
	input wire logic LATE_CHECK_EN_I,
	input wire logic [LATE_W-1:0] LATE_LIMIT_I,
	output logic OUT_VALID_O,
	input wire logic OUT_READY_I,
	output logic OUT_DUMMY_O,
	output logic [2:0] OUT_SN_O,
	output logic SN_STB_O,
	output logic SN_VALID_O,
	output logic [2:0] SN_O,
	output logic CSI_O,
	output logic CD_STATE_O,
	output logic [7:0] HDR_ERR_CNT_O,
	output logic SEQ_ERR_O,
	output logic MISINS_O,
	output logic LOST_O
);
	// ==========================================================
	// Correction and detection stage
	aqc_pkg::aqc_cd_e cd_state_ff;
	aqc_pkg::aqc_cd_e cd_nxt_state;
	logic cd_valid;
	logic [3:0] cd_sn4;
	logic cd_crc_err;
	logic cd_par_err;
	logic cd_err;
	logic [7:0] err_cnt_ff;

	aqc_corr u_corr (
		.hdr_i(CELL_HDR_I),
		.state_i(cd_state_ff),
		.valid_o(cd_valid),
		.sn_o(cd_sn4),
		.crc_err_o(cd_crc_err),
		.par_err_o(cd_par_err),
		.hdr_err_o(cd_err),
		.nxt_state_o(cd_nxt_state)
	);

	// Only the three low bits are ordered; the top bit is the CSI.
	wire [2:0] rx_sn = cd_sn4[aqc_pkg::SN_W-1:0];
	wire rx_csi = cd_sn4[aqc_pkg::SN_W];

	// ==========================================================
	// Ordering stage state
	aqc_pkg::aqc_fast_e state_ff;
	aqc_pkg::aqc_fast_e nxt_state;
	logic [2:0] last_sn_ff;
	logic [2:0] nxt_last_sn;
	logic [2:0] last_good_ff;
	logic [2:0] nxt_last_good;
	logic [2:0] dummy_cnt_ff;
	logic [2:0] nxt_dummy_cnt;
	logic [2:0] gap_sn_ff;
	logic [2:0] nxt_gap_sn;
	logic acc_pend_ff;
	logic nxt_acc_pend;
	logic [2:0] acc_sn_ff;
	logic [2:0] nxt_acc_sn;
	logic timer_en_ff;
	logic nxt_timer_en;
	logic [LATE_W-1:0] late_cnt_ff;
	logic seq_err;
	logic misins;
	logic lost;
	logic arm;

	wire [2:0] exp1 = last_sn_ff + aqc_pkg::SN_STEP;
	wire [2:0] exp2 = last_sn_ff + aqc_pkg::SN_STEP2;
	wire [2:0] prev1 = last_sn_ff - aqc_pkg::SN_STEP;
	wire [2:0] good2 = last_good_ff + aqc_pkg::SN_STEP2;
	wire [2:0] good_gap = rx_sn - last_good_ff - aqc_pkg::SN_STEP;

	// ==========================================================
	// Handshakes and buffer feed
	// A new header is refused while any dummy or accepted cell still waits
	// for buffer space, so the buffer order always matches the decisions.
	wire emit_busy = (dummy_cnt_ff != 3'h0) || acc_pend_ff;
	wire cell_ready = (state_ff != aqc_pkg::FS_RESET) && !emit_busy;
	wire cell_take = CELL_VALID_I && cell_ready;
	wire fifo_in_ready;
	wire fifo_wr = emit_busy;
	wire emit_dummy = dummy_cnt_ff != 3'h0;
	wire [3:0] fifo_din = emit_dummy ? {1'b1, gap_sn_ff} : {1'b0, acc_sn_ff};
	wire emit_done = fifo_wr && fifo_in_ready;
	wire late_hit = late_cnt_ff >= LATE_LIMIT_I;
	wire timeout = (state_ff == aqc_pkg::FS_SYNC) && timer_en_ff && LATE_CHECK_EN_I
		&& late_hit && cell_ready && !CELL_VALID_I;

	assign CELL_READY_O = cell_ready;

	aqc_fifo #(
		.WIDTH(aqc_pkg::FIFO_WIDTH),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk_i(CLK_SYS_I),
		.reset_n_i(RESET_N_I),
		.in_valid_i(fifo_wr),
		.in_ready_o(fifo_in_ready),
		.in_data_i(fifo_din),
		.out_valid_o(OUT_VALID_O),
		.out_ready_i(OUT_READY_I),
		.out_data_o({OUT_DUMMY_O, OUT_SN_O})
	);

	// ==========================================================
	// Ordering decisions
	always_comb
	begin
		nxt_state = state_ff;
		nxt_last_sn = last_sn_ff;
		nxt_last_good = last_good_ff;
		nxt_dummy_cnt = dummy_cnt_ff;
		nxt_gap_sn = gap_sn_ff;
		nxt_acc_pend = acc_pend_ff;
		nxt_acc_sn = acc_sn_ff;
		seq_err = 1'b0;
		misins = 1'b0;
		lost = 1'b0;
		arm = 1'b0;
		if (emit_done)
		begin
			if (emit_dummy)
			begin
				nxt_dummy_cnt = dummy_cnt_ff - aqc_pkg::SN_STEP;
				nxt_gap_sn = gap_sn_ff + aqc_pkg::SN_STEP;
			end
			else
				nxt_acc_pend = 1'b0;
		end
		if (timeout)
		begin
			nxt_state = aqc_pkg::FS_LATE_INS;
			nxt_dummy_cnt = 3'h1;
			nxt_gap_sn = exp1;
		end
		if (cell_take)
		begin
			nxt_acc_sn = rx_sn;
			if (cd_valid)
				nxt_last_sn = rx_sn;
			unique case (state_ff)
				aqc_pkg::FS_START:
				begin
					if (cd_valid)
						nxt_state = aqc_pkg::FS_UNLOCKED;
				end
				aqc_pkg::FS_UNLOCKED:
				begin
					if (!cd_valid)
						nxt_state = aqc_pkg::FS_START;
					else if (rx_sn == exp1)
					begin
						nxt_state = aqc_pkg::FS_SYNC;
						nxt_acc_pend = 1'b1;
						nxt_last_good = rx_sn;
						arm = 1'b1;
					end
				end
				aqc_pkg::FS_SYNC:
				begin
					nxt_acc_pend = 1'b1;
					if (!cd_valid)
						nxt_state = aqc_pkg::FS_INVALID;
					else if (rx_sn == exp1)
					begin
						nxt_last_good = rx_sn;
						arm = 1'b1;
					end
					else if (rx_sn == exp2)
					begin
						nxt_state = aqc_pkg::FS_LOSS_MIS;
						nxt_dummy_cnt = 3'h1;
						nxt_gap_sn = exp1;
						nxt_last_good = rx_sn;
						seq_err = 1'b1;
					end
					else
					begin
						nxt_state = aqc_pkg::FS_OUT_OF_SEQ;
						seq_err = 1'b1;
					end
				end
				aqc_pkg::FS_INVALID:
				begin
					if (!cd_valid)
						nxt_state = aqc_pkg::FS_START;
					else if (rx_sn == last_good_ff + aqc_pkg::SN_STEP)
					begin
						nxt_state = aqc_pkg::FS_SYNC;
						misins = 1'b1;
						arm = 1'b1;
					end
					else if (rx_sn == good2)
					begin
						nxt_state = aqc_pkg::FS_SYNC;
						nxt_acc_pend = 1'b1;
						nxt_last_good = rx_sn;
						arm = 1'b1;
					end
					else
						nxt_state = aqc_pkg::FS_UNLOCKED;
				end
				aqc_pkg::FS_OUT_OF_SEQ:
				begin
					if (!cd_valid)
						nxt_state = aqc_pkg::FS_START;
					else if (rx_sn == exp1)
					begin
						// Fill the gap from the last good cell, up to seven dummies.
						nxt_state = aqc_pkg::FS_SYNC;
						nxt_dummy_cnt = good_gap;
						nxt_gap_sn = last_good_ff + aqc_pkg::SN_STEP;
						nxt_acc_pend = 1'b1;
						nxt_last_good = rx_sn;
						lost = 1'b1;
						arm = 1'b1;
					end
					else if (rx_sn == good2)
					begin
						nxt_state = aqc_pkg::FS_SYNC;
						nxt_acc_pend = 1'b1;
						nxt_last_good = rx_sn;
						arm = 1'b1;
					end
					else
						nxt_state = aqc_pkg::FS_UNLOCKED;
				end
				aqc_pkg::FS_LOSS_MIS:
				begin
					if (cd_valid && rx_sn == exp1)
					begin
						nxt_state = aqc_pkg::FS_SYNC;
						nxt_acc_pend = 1'b1;
						nxt_last_good = rx_sn;
					end
					else if (cd_valid && rx_sn == prev1)
					begin
						nxt_state = aqc_pkg::FS_SYNC;
						nxt_last_sn = last_sn_ff;
						misins = 1'b1;
					end
					else if (cd_valid && rx_sn == last_sn_ff)
						nxt_state = aqc_pkg::FS_SYNC;
					else
						nxt_state = cd_valid ? aqc_pkg::FS_UNLOCKED : aqc_pkg::FS_START;
				end
				aqc_pkg::FS_LATE_INS:
				begin
					if (cd_valid && rx_sn == exp1)
					begin
						nxt_state = aqc_pkg::FS_SYNC;
						nxt_last_good = rx_sn;
					end
					else if (cd_valid && rx_sn == exp2)
					begin
						nxt_state = aqc_pkg::FS_SYNC;
						nxt_acc_pend = 1'b1;
						nxt_last_good = rx_sn;
					end
					else
						nxt_state = cd_valid ? aqc_pkg::FS_UNLOCKED : aqc_pkg::FS_START;
				end
				aqc_pkg::FS_RESET:
				begin
					nxt_state = aqc_pkg::FS_START;
				end
			endcase
		end
		else if (state_ff == aqc_pkg::FS_RESET)
			nxt_state = aqc_pkg::FS_START;
	end

	// The timer stays armed through the loss and late states and is dropped
	// whenever the machine falls out of lock.
	always_comb
	begin
		nxt_timer_en = timer_en_ff;
		if (arm)
			nxt_timer_en = 1'b1;
		else if (nxt_state == aqc_pkg::FS_START || nxt_state == aqc_pkg::FS_UNLOCKED)
			nxt_timer_en = 1'b0;
	end

	// ==========================================================
	// Registers
	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RESET_N_I)
		begin
			state_ff <= aqc_pkg::FS_RESET;
			last_sn_ff <= 3'h0;
			last_good_ff <= 3'h0;
			dummy_cnt_ff <= 3'h0;
			gap_sn_ff <= 3'h0;
			acc_pend_ff <= 1'b0;
			acc_sn_ff <= 3'h0;
			timer_en_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			last_sn_ff <= nxt_last_sn;
			last_good_ff <= nxt_last_good;
			dummy_cnt_ff <= nxt_dummy_cnt;
			gap_sn_ff <= nxt_gap_sn;
			acc_pend_ff <= nxt_acc_pend;
			acc_sn_ff <= nxt_acc_sn;
			timer_en_ff <= nxt_timer_en;
		end
	end

	// The late counter saturates so a stalled link cannot wrap it past the limit.
	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RESET_N_I || cell_take || state_ff != aqc_pkg::FS_SYNC)
			late_cnt_ff <= '0;
		else if (!(&late_cnt_ff))
			late_cnt_ff <= late_cnt_ff + LATE_W'(1);
	end

	// Per-cell write-back of the correction state and header error count.
	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RESET_N_I)
		begin
			cd_state_ff <= aqc_pkg::CD_CORRECT;
			err_cnt_ff <= aqc_pkg::ERR_CNT_RST;
		end
		else if (cell_take)
		begin
			cd_state_ff <= cd_nxt_state;
			err_cnt_ff <= err_cnt_ff + (cd_err ? aqc_pkg::ERR_CNT_INC : 8'h00);
		end
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RESET_N_I)
		begin
			SN_STB_O <= 1'b0;
			SN_VALID_O <= 1'b0;
			SN_O <= 3'h0;
			CSI_O <= 1'b0;
			SEQ_ERR_O <= 1'b0;
			MISINS_O <= 1'b0;
			LOST_O <= 1'b0;
		end
		else
		begin
			SN_STB_O <= cell_take;
			SEQ_ERR_O <= seq_err;
			MISINS_O <= misins;
			LOST_O <= lost;
			if (cell_take)
			begin
				SN_VALID_O <= cd_valid;
				SN_O <= rx_sn;
				CSI_O <= rx_csi;
			end
		end
	end

	assign CD_STATE_O = cd_state_ff;
	assign HDR_ERR_CNT_O = err_cnt_ff;

	// ==========================================================
	// Checks
	default clocking cb @(posedge CLK_SYS_I);
	endclocking
	default disable iff (!RESET_N_I);

	sequence s_loss_seen;
		cell_take && state_ff == aqc_pkg::FS_SYNC && cd_valid && rx_sn == exp2;
	endsequence
	sequence s_dummy_first;
		state_ff == aqc_pkg::FS_LOSS_MIS && dummy_cnt_ff == 3'h1 && acc_pend_ff
			&& fifo_wr && fifo_din[3];
	endsequence

	property p_reset_start;
		@(posedge CLK_SYS_I) disable iff (1'b0)
		!RESET_N_I ##1 RESET_N_I |-> state_ff == aqc_pkg::FS_RESET
			##1 state_ff == aqc_pkg::FS_START;
	endproperty
	a_reset_start: assert property (p_reset_start) else $error("no start after reset");

	property p_crc_only;
		cell_take && cd_crc_err && !cd_par_err |-> !cd_valid
			##1 CD_STATE_O == aqc_pkg::CD_DETECT && !SN_VALID_O;
	endproperty
	a_crc_only: assert property (p_crc_only) else $error("crc-only byte judged valid");

	property p_err_count;
		cell_take && cd_err |=> HDR_ERR_CNT_O == $past(HDR_ERR_CNT_O) + aqc_pkg::ERR_CNT_INC;
	endproperty
	a_err_count: assert property (p_err_count) else $error("header error not counted");

	property p_raw_sn;
		cell_take && !cd_valid |=> SN_STB_O && !SN_VALID_O
			&& SN_O == $past(CELL_HDR_I[aqc_pkg::HDR_SN_MSB:aqc_pkg::HDR_SN_LSB]);
	endproperty
	a_raw_sn: assert property (p_raw_sn) else $error("invalid byte sn altered");

	property p_unlock_bad;
		cell_take && state_ff == aqc_pkg::FS_UNLOCKED && !cd_valid
			|=> state_ff == aqc_pkg::FS_START && !emit_busy;
	endproperty
	a_unlock_bad: assert property (p_unlock_bad) else $error("invalid cell kept lock");

	property p_lock;
		cell_take && state_ff == aqc_pkg::FS_UNLOCKED && cd_valid && rx_sn == exp1
			|=> state_ff == aqc_pkg::FS_SYNC && acc_pend_ff && timer_en_ff
			&& acc_sn_ff == $past(rx_sn);
	endproperty
	a_lock: assert property (p_lock) else $error("in-order cell did not lock");

	property p_single_loss;
		s_loss_seen |=> s_dummy_first;
	endproperty
	a_single_loss: assert property (p_single_loss) else $error("loss dummy missing");

	property p_misins;
		cell_take && state_ff == aqc_pkg::FS_LOSS_MIS && cd_valid && rx_sn == prev1
			|=> state_ff == aqc_pkg::FS_SYNC && !emit_busy && MISINS_O;
	endproperty
	a_misins: assert property (p_misins) else $error("late cell not dropped");

	property p_late;
		timeout |=> state_ff == aqc_pkg::FS_LATE_INS && dummy_cnt_ff == 3'h1 && !acc_pend_ff;
	endproperty
	a_late: assert property (p_late) else $error("timeout dummy missing");

	property p_late_drop;
		cell_take && state_ff == aqc_pkg::FS_LATE_INS && cd_valid && rx_sn == exp1
			|=> state_ff == aqc_pkg::FS_SYNC && !emit_busy;
	endproperty
	a_late_drop: assert property (p_late_drop) else $error("late cell stored");
endmodule : aqc_seq_checker

//--- aqc_sink.sv
`timescale 1ns/1ps
module aqc_sink (
	input wire logic clk_i,
	input wire logic stall_i,
	input wire logic slow_i,
	input wire logic valid_i,
	input wire logic dummy_i,
	input wire logic [2:0] sn_i,
	output logic ready_o
);
	// ==========================================================
	// Consumer of the reassembly buffer
	logic [3:0] got[$];
	logic fire;
	logic [3:0] word;
	logic tog;

	initial
	begin
		ready_o = 1'h0;
		tog = 1'h0;
		fire = 1'h0;
		word = 4'h0;
	end

	// Outputs are sampled on the falling edge so the pop never races the write edge.
	always @(negedge clk_i)
	begin
		fire = (valid_i === 1'h1) && (ready_o === 1'h1);
		word = {dummy_i, sn_i};
	end

	// Slow mode accepts only every other cycle, which keeps the buffer partly full.
	always @(posedge clk_i)
	begin
		if (fire)
			got.push_back(word);
		tog = ~tog;
		ready_o <= #1 ~stall_i & (~slow_i | tog);
	end
endmodule : aqc_sink

//--- testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin err_count++; \
	$display("[FAIL] %s expected %h seen %h", n, e, a); end end
module testbench;
	// ==========================================================
	// Signals and instances
	logic clk_sys = 1'h0;
	logic reset_n = 1'h0;
	logic cell_valid = 1'h0;
	logic [7:0] cell_hdr = 8'h00;
	logic late_en = 1'h0;
	logic [15:0] late_limit = 16'h000a;
	logic stall = 1'h0;
	logic slow = 1'h0;
	logic cell_ready, out_valid, out_ready, out_dummy, sn_stb, sn_valid, csi, cd_state;
	logic seq_err, misins, lost, seq_p, mis_p, lost_p;
	logic [2:0] out_sn, sn;
	logic [7:0] hdr_err_cnt, ecnt;
	logic [3:0] exp_q[$];
	int err_count = 0;
	int checks_done = 0;

	always #5 clk_sys = ~clk_sys;

	aqc_seq_checker #(.LATE_W(16), .DEPTH(4)) i_dut (
		.CLK_SYS_I(clk_sys), .RESET_N_I(reset_n), .CELL_VALID_I(cell_valid),
		.CELL_READY_O(cell_ready), .CELL_HDR_I(cell_hdr), .LATE_CHECK_EN_I(late_en),
		.LATE_LIMIT_I(late_limit), .OUT_VALID_O(out_valid), .OUT_READY_I(out_ready),
		.OUT_DUMMY_O(out_dummy), .OUT_SN_O(out_sn), .SN_STB_O(sn_stb),
		.SN_VALID_O(sn_valid), .SN_O(sn), .CSI_O(csi), .CD_STATE_O(cd_state),
		.HDR_ERR_CNT_O(hdr_err_cnt), .SEQ_ERR_O(seq_err), .MISINS_O(misins), .LOST_O(lost)
	);

	aqc_sink i_sink (
		.clk_i(clk_sys), .stall_i(stall), .slow_i(slow), .valid_i(out_valid),
		.dummy_i(out_dummy), .sn_i(out_sn), .ready_o(out_ready)
	);

	// ==========================================================
	// Helpers
	function automatic logic [7:0] hdr(input logic [3:0] d);
		logic [6:0] r;
		logic [7:0] h;
		r = {d, 3'h0};
		for (int i = 6; i >= 3; i--)
			if (r[i])
				r[i -: 4] = r[i -: 4] ^ 4'hb;
		h = {d, r[2:0], 1'h0};
		h[0] = ^h;
		return h;
	endfunction : hdr

	task automatic do_reset;
		reset_n = 1'h0;
		repeat (20) @(posedge clk_sys);
		#1;
		`CHK("ready_in_reset", 1'h0, cell_ready)
		`CHK("cnt_in_reset", 8'h00, hdr_err_cnt)
		reset_n = 1'h1;
		i_sink.got.delete();
		exp_q.delete();
		ecnt = 8'h00;
	endtask : do_reset

	// Offers one header, holds it until taken and snapshots the one-cycle pulses.
	task automatic send(input logic [7:0] h);
		int n;
		n = 0;
		cell_hdr = h;
		cell_valid = 1'h1;
		while (cell_ready !== 1'h1 && n < 100)
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		`CHK("cell_ready", 1'h1, cell_ready)
		@(posedge clk_sys);
		#1;
		cell_valid = 1'h0;
		`CHK("sn_stb", 1'h1, sn_stb)
		seq_p = seq_err;
		mis_p = misins;
		lost_p = lost;
		@(posedge clk_sys);
		#1;
	endtask : send

	task automatic ew(input logic dm, input logic [2:0] s);
		exp_q.push_back({dm, s});
	endtask : ew

	task automatic cmpq;
		repeat (8) @(posedge clk_sys);
		#1;
		`CHK("word_count", exp_q.size(), i_sink.got.size())
		foreach (exp_q[i])
			if (i < i_sink.got.size())
				`CHK("word", exp_q[i], i_sink.got[i])
		exp_q.delete();
		i_sink.got.delete();
	endtask : cmpq

	task automatic cd(input logic [3:0] d, input logic [7:0] f, input logic ev,
		input logic es, input logic [7:0] inc);
		logic [7:0] h;
		h = hdr(d) ^ f;
		send(h);
		ecnt = ecnt + inc;
		`CHK("sn_valid", ev, sn_valid)
		`CHK("sn", (ev ? d[2:0] : h[6:4]), sn)
		`CHK("csi", (ev ? d[3] : h[7]), csi)
		`CHK("cd_state", es, cd_state)
		`CHK("hdr_err_cnt", ecnt, hdr_err_cnt)
	endtask : cd

	// ==========================================================
	// Scenarios
	task automatic t_corr;
		do_reset;
		cd(4'ha, 8'h00, 1'h1, 1'h0, 8'h00);
		cd(4'h3, 8'h01, 1'h1, 1'h1, 8'h01);
		cd(4'h5, 8'h00, 1'h1, 1'h0, 8'h00);
		cd(4'hd, 8'h06, 1'h0, 1'h1, 8'h01);
		cd(4'h6, 8'h01, 1'h0, 1'h1, 8'h01);
		cd(4'h7, 8'h00, 1'h1, 1'h0, 8'h00);
		cd(4'h9, 8'h10, 1'h1, 1'h1, 8'h01);
		cd(4'h2, 8'h10, 1'h0, 1'h1, 8'h01);
		cd(4'h4, 8'h00, 1'h1, 1'h0, 8'h00);
		$display("t_corr done");
	endtask : t_corr

	task automatic t_sync;
		do_reset;
		slow = 1'h1;
		send(hdr(4'h5) ^ 8'h06);
		send(hdr(4'h5));
		send(hdr(4'h6) ^ 8'h06);
		send(hdr(4'h6));
		send(hdr(4'h0));
		send(hdr(4'h1));
		ew(1'h0, 3'h1);
		send(hdr(4'h2));
		ew(1'h0, 3'h2);
		cmpq;
		slow = 1'h0;
		$display("t_sync done");
	endtask : t_sync

	task automatic t_loss;
		send(hdr(4'h4));
		`CHK("seq_err", 1'h1, seq_p)
		ew(1'h1, 3'h3);
		ew(1'h0, 3'h4);
		send(hdr(4'h5));
		ew(1'h0, 3'h5);
		send(hdr(4'h7));
		ew(1'h1, 3'h6);
		ew(1'h0, 3'h7);
		send(hdr(4'h6));
		`CHK("misins", 1'h1, mis_p)
		send(hdr(4'h0));
		ew(1'h0, 3'h0);
		send(hdr(4'h2));
		ew(1'h1, 3'h1);
		ew(1'h0, 3'h2);
		send(hdr(4'h2));
		send(hdr(4'h3));
		ew(1'h0, 3'h3);
		cmpq;
		$display("t_loss done");
	endtask : t_loss

	task automatic t_late;
		late_limit = 16'h000a;
		late_en = 1'h1;
		repeat (30) @(posedge clk_sys);
		#1;
		ew(1'h1, 3'h4);
		send(hdr(4'h4));
		repeat (30) @(posedge clk_sys);
		#1;
		ew(1'h1, 3'h5);
		send(hdr(4'h6));
		ew(1'h0, 3'h6);
		late_en = 1'h0;
		cmpq;
		$display("t_late done");
	endtask : t_late

	// The fifth cell is taken but cannot be written, so the cell port must stay closed.
	task automatic t_fifo;
		stall = 1'h1;
		for (int i = 7; i < 12; i++)
		begin
			send(hdr(4'(i % 8)));
			ew(1'h0, 3'(i % 8));
		end
		repeat (5) @(posedge clk_sys);
		#1;
		`CHK("ready_full", 1'h0, cell_ready)
		`CHK("out_valid_full", 1'h1, out_valid)
		stall = 1'h0;
		cmpq;
		`CHK("out_valid_empty", 1'h0, out_valid)
		$display("t_fifo done");
	endtask : t_fifo

	// A jump in lock and an invalid cell in lock drive the two recovery states.
	task automatic t_oos;
		send(hdr(4'h6));
		`CHK("seq_err_oos", 1'h1, seq_p)
		ew(1'h0, 3'h6);
		send(hdr(4'h7));
		`CHK("lost", 1'h1, lost_p)
		ew(1'h1, 3'h4);
		ew(1'h1, 3'h5);
		ew(1'h1, 3'h6);
		ew(1'h0, 3'h7);
		send(hdr(4'h0) ^ 8'h06);
		ew(1'h0, 3'h0);
		send(hdr(4'h0));
		`CHK("misins_inv", 1'h1, mis_p)
		send(hdr(4'h1));
		ew(1'h0, 3'h1);
		cmpq;
		$display("t_oos done");
	endtask : t_oos

	// ==========================================================
	// Run control
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : test_done

	initial
	begin
		t_corr;
		t_sync;
		t_loss;
		t_late;
		t_fifo;
		t_oos;
		test_done;
	end

	// The whole run needs well under a thousand cycles; this margin only catches hangs.
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		err_count++;
		test_done;
	end
endmodule : testbench
